// ==== hdl/spibd_cfg.svh ====
// register map, field positions and reset values of the spi data/status block
`ifndef SPIBD_CFG_SVH
`define SPIBD_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SPIBD_OFF_CTRL1   5'h00
`define SPIBD_OFF_CTRL2   5'h04
`define SPIBD_OFF_BAUD    5'h08
`define SPIBD_OFF_STATUS  5'h0C
`define SPIBD_OFF_DATA    5'h10

// ****************************************************************
// control_reg_one fields
// ****************************************************************
`define SPIBD_C1_RXIE     7
`define SPIBD_C1_EN       6
`define SPIBD_C1_TXIE     5
`define SPIBD_C1_MASTER_SELECT     4
`define SPIBD_C1_CPOL     3
`define SPIBD_C1_CLOCK_PHASE_SELECT     2
`define SPIBD_C1_SELECT_OUTPUT_ENABLE     1
`define SPIBD_C1_LSBF     0

// ****************************************************************
// control two and status fields
// ****************************************************************
`define SPIBD_C2_FAULT_DETECT_ENABLE   4
`define SPIBD_ST_RXF      7
`define SPIBD_ST_TXE      5
`define SPIBD_ST_MF       4

// ****************************************************************
// reset values and frame length
// ****************************************************************
`define SPIBD_RST_CTRL1   8'h04
`define SPIBD_RST_CTRL2   8'h00
`define SPIBD_RST_BAUD    8'h00
`define SPIBD_RST_DATA    8'h00
`define SPIBD_LAST_EDGE   5'h0F

`endif

// ==== hdl/spibd_pkg.sv ====
// types shared by the spi data/status block
package spibd_pkg;

    // ****************************************************************
    // transfer sequencer states
    // ****************************************************************
    typedef enum logic [1:0]
    {
        SPIBD_IDLE = 2'h0,
        SPIBD_RUN  = 2'h1,
        SPIBD_END  = 2'h3
    } spibd_state_t;

endpackage

// ==== hdl/spibd_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module spibd_sync
    import spibd_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] meta;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// ==== hdl/spibd_shifter.sv ====
// eight bit shift register with sampled input bit and bit order select
`timescale 1ns/1ps
`default_nettype none

module spibd_shifter
    import spibd_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_data,
    input  wire logic         sample,
    input  wire logic         sample_bit,
    input  wire logic         shift,
    input  wire logic         lsb_first,
    output logic              out_bit,
    output logic      [W-1:0] shifted,
    output logic      [W-1:0] held
);

    logic [W-1:0] sr;
    logic         in_bit;

    // ****************************************************************
    // bit order selection
    // ****************************************************************
    assign out_bit = lsb_first ? sr[0] : sr[W-1];     // [R19]
    assign held    = sr;
    assign shifted = lsb_first ? {in_bit, sr[W-1:1]}
                               : {sr[W-2:0], in_bit};

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sr     <= '0;
            in_bit <= 1'b0;
        end
        else
        begin
            if (sample)
                in_bit <= sample_bit;                 // [R16]
            if (load)
                sr <= load_data;
            else if (shift)
                sr <= shifted;                        // [R16]
        end
    end

endmodule

`default_nettype wire

// ==== hdl/spibd_top.sv ====
// spi data path, buffers, status flags and avalon register slave
// Functional notes
// R01 - receive-full (status bit 7) sets when a transfer completes
// R02 - receive-full clears on status read while set, then data read
// R03 - transmit-empty (status bit 5) is one while transmit buffer has room
// R04 - transmit-empty clears on status read while set, then data write
// R05 - data writes are dropped unless status was read with transmit-empty set
// R06 - transmit interrupt while transmit-empty and its enable are set
// R07 - transmit-empty sets whenever a byte moves buffer to shifter
// R08 - idle module moves a written byte at once, flag back within two cycles; only a master does, an idle slave waits for select to fall
// R09 - with nothing queued at transfer end, flag stays set, nothing moves
// R10 - mode-fault (bit 4) sets on select low in master, detect on, no ss out
// R11 - mode-fault clears on status read while set, then control one write
// R12 - status bits 6,3,2,1,0 read zero; status writes ignored
// R13 - data reads give receive buffer, writes fill transmit buffer; reset 0
// R14 - in master mode a byte written to the buffer starts a transfer
// R15 - unread receive buffer keeps old byte, new byte dropped, no indication
// R16 - sample on one clock edge, shift half a clock later
// R17 - a transfer is eight clock cycles, eight bits out and eight in
// R18 - at end, store received byte, then load queued byte and restart
// R19 - msb first by default, lsb first when bit order bit is set
// R20 - remote master holds select low for the whole transfer
// R21 - select returns high between transfers with phase zero only
// R22 - mode fault clears master select and turns clock and data drivers off
// R23 - interrupt when receive-full or mode-fault set with its enable
// R24 - reset gives flags 0, transmit-empty 1, buffers and shifter empty
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "spibd_cfg.svh"

module spibd_top
    import spibd_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe,
    input  wire logic              ss_n_in,
    output logic                   ss_n_out,
    output logic                   ss_n_oe,
    output logic                   tx_irq,
    output logic                   rx_fault_irq
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    generate
        if (ADDR_W < 5)
        begin : g_bad_addr
            $error("spibd_top: ADDR_W must be at least 5");
        end
    endgenerate

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [4:0] off);
        hit = (a[4:2] == off[4:2]) && ((a >> 5) == '0);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]   control_reg_one;
    logic [7:0]   ctrl_two;
    logic [7:0]   baud;
    logic [7:0]   rx_buf;
    logic [7:0]   tx_buf;
    logic         rx_full_flag;
    logic         tx_empty_flag;
    logic         mode_fault_flag;
    logic         arm_rx;
    logic         arm_tx;
    logic         arm_mf;
    spibd_state_t state;
    logic [4:0]   edge_cnt;
    logic [10:0]  div_cnt;
    logic         sck_gen;
    logic         sck_prev;
    logic         ss_prev;
    logic [3:0]   pins_s;

    // ****************************************************************
    // pin synchroniser and shifter
    // ****************************************************************
    logic       sck_s;
    logic       mosi_s;
    logic       miso_s;
    logic       ss_s;
    logic       load;
    logic       sample_now;
    logic       shift_now;
    logic       out_bit;
    logic [7:0] shifted;
    logic [7:0] held;

    spibd_sync #(.W(4)) u_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   ({sck_in, mosi_in, miso_in, !ss_n_in}),
        .dout  (pins_s)
    );

    assign {sck_s, mosi_s, miso_s, ss_s} = {pins_s[3:1], !pins_s[0]};

    // ****************************************************************
    // control decode
    // ****************************************************************
    wire en     = control_reg_one[`SPIBD_C1_EN];
    wire master = control_reg_one[`SPIBD_C1_MASTER_SELECT];
    wire cpol   = control_reg_one[`SPIBD_C1_CPOL];
    wire clock_phase_select   = control_reg_one[`SPIBD_C1_CLOCK_PHASE_SELECT];
    wire select_output_enable   = control_reg_one[`SPIBD_C1_SELECT_OUTPUT_ENABLE];
    wire lsbf   = control_reg_one[`SPIBD_C1_LSBF];
    wire fault_detect_enable = ctrl_two[`SPIBD_C2_FAULT_DETECT_ENABLE];
    wire queued = !tx_empty_flag;

    spibd_shifter #(.W(8)) u_shift
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .load       (load && queued),
        .load_data  (tx_buf),
        .sample     (sample_now),
        .sample_bit (master ? miso_s : mosi_s),
        .shift      (shift_now),
        .lsb_first  (lsbf),
        .out_bit    (out_bit),
        .shifted    (shifted),
        .held       (held)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire acc      = (avs_read || avs_write) && !avs_waitrequest;
    wire rd_acc   = acc && avs_read;
    wire wr_acc   = acc && avs_write && avs_byteenable[0];
    wire st_rd    = rd_acc && hit(avs_address, `SPIBD_OFF_STATUS);
    wire data_rd  = rd_acc && hit(avs_address, `SPIBD_OFF_DATA);
    wire data_wr  = wr_acc && hit(avs_address, `SPIBD_OFF_DATA);
    wire c1_wr    = wr_acc && hit(avs_address, `SPIBD_OFF_CTRL1);
    wire c2_wr    = wr_acc && hit(avs_address, `SPIBD_OFF_CTRL2);
    wire baud_wr  = wr_acc && hit(avs_address, `SPIBD_OFF_BAUD);
    wire data_ok  = data_wr && arm_tx && tx_empty_flag;       // [R05]

    wire [7:0] status_val = {rx_full_flag, 1'b0, tx_empty_flag,
                             mode_fault_flag, 4'h0};          // [R12]
    wire [7:0] rd_byte =
        hit(avs_address, `SPIBD_OFF_CTRL1)  ? control_reg_one :
        hit(avs_address, `SPIBD_OFF_CTRL2)  ? ctrl_two :
        hit(avs_address, `SPIBD_OFF_BAUD)   ? baud :
        hit(avs_address, `SPIBD_OFF_STATUS) ? status_val :
        hit(avs_address, `SPIBD_OFF_DATA)   ? rx_buf :        // [R13]
        8'h00;

    // ****************************************************************
    // mode fault
    // ****************************************************************
    wire mf_set = en && master && fault_detect_enable && !select_output_enable && !ss_s;   // [R10]

    // ****************************************************************
    // serial clock edges
    // ****************************************************************
    wire [10:0] half_cnt = (11'(baud[6:4]) + 11'h001) << baud[2:0];
    wire tick   = (state == SPIBD_RUN) && (div_cnt == half_cnt - 11'h001);
    wire m_edge = master && tick;
    wire s_edge = !master && (state == SPIBD_RUN) && !ss_s &&
                  (sck_s != sck_prev);
    wire sck_edge = m_edge || s_edge;
    wire lead     = !edge_cnt[0];
    wire last     = sck_edge && (edge_cnt == `SPIBD_LAST_EDGE); // [R17]
    wire ss_fall  = ss_prev && !ss_s;

    assign sample_now = sck_edge && (clock_phase_select ? !lead : lead);   // [R16]
    assign shift_now  = sck_edge && (clock_phase_select ? (lead && edge_cnt != 5'h00)
                                          : !lead);           // [R16]

    // ****************************************************************
    // transfer start and continuation
    // ****************************************************************
    wire start_m = master && queued;                          // [R14]
    wire start_s = !master && ss_fall;                        // [R20]
    wire cont_s  = !master && clock_phase_select && !ss_s;                  // [R21]
    wire idle_go = (state == SPIBD_IDLE) && en && !mf_set &&
                   (start_m || start_s);
    wire end_go  = (state == SPIBD_END) && en && !mf_set &&
                   (start_m || cont_s);                       // [R18]
    assign load  = idle_go || end_go;
    wire move    = load && queued;                            // [R09]
    wire capture = (state == SPIBD_END) && en;
    wire [7:0] rx_byte = clock_phase_select ? shifted : held;

    logic         abort;
    spibd_state_t next_state;
    assign abort = !en || mf_set ||
                   (!master && (state == SPIBD_RUN) && ss_s);

    always_comb
    begin
        next_state = state;
        case (state)
            SPIBD_IDLE:
                if (load)
                    next_state = SPIBD_RUN;
            SPIBD_RUN:
                if (abort)
                    next_state = SPIBD_IDLE;
                else if (last)
                    next_state = SPIBD_END;
            SPIBD_END:
                if (load)
                    next_state = SPIBD_RUN;
                else
                    next_state = SPIBD_IDLE;
            default:
                next_state = SPIBD_IDLE;
        endcase
    end

    // ****************************************************************
    // flag next values
    // ****************************************************************
    wire next_rx_full  = capture ||                           // [R01]
                         (rx_full_flag && !(data_rd && arm_rx)); // [R02]
    wire next_tx_empty = move ? 1'b1 :                        // [R07] [R08]
                         (data_ok ? 1'b0 : tx_empty_flag);    // [R03] [R04]
    wire next_mf       = mf_set ||
                         (mode_fault_flag && !(c1_wr && arm_mf)); // [R11]
    wire [7:0] shown   = avs_readdata[7:0];
    wire next_arm_rx   = st_rd ? shown[`SPIBD_ST_RXF] : (arm_rx && !data_rd);
    wire next_arm_tx   = st_rd ? shown[`SPIBD_ST_TXE] : (arm_tx && !data_wr);
    wire next_arm_mf   = st_rd ? shown[`SPIBD_ST_MF] : (arm_mf && !c1_wr);

    // ****************************************************************
    // registers and flags
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            control_reg_one <= `SPIBD_RST_CTRL1;
            ctrl_two        <= `SPIBD_RST_CTRL2;
            baud            <= `SPIBD_RST_BAUD;
        end
        else
        begin
            if (c1_wr)
                control_reg_one <= avs_writedata[7:0];
            if (mf_set)
                control_reg_one[`SPIBD_C1_MASTER_SELECT] <= 1'b0;      // [R22]
            if (c2_wr)
                ctrl_two <= avs_writedata[7:0];
            if (baud_wr)
                baud <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rx_buf          <= `SPIBD_RST_DATA;               // [R24]
            tx_buf          <= `SPIBD_RST_DATA;
            rx_full_flag    <= 1'b0;
            tx_empty_flag   <= 1'b1;
            mode_fault_flag <= 1'b0;
            arm_rx          <= 1'b0;
            arm_tx          <= 1'b0;
            arm_mf          <= 1'b0;
        end
        else
        begin
            if (capture && !rx_full_flag)
                rx_buf <= rx_byte;                            // [R15] [R18]
            if (data_ok)
                tx_buf <= avs_writedata[7:0];                 // [R13]
            rx_full_flag    <= next_rx_full;
            tx_empty_flag   <= next_tx_empty;
            mode_fault_flag <= next_mf;
            arm_rx          <= next_arm_rx;
            arm_tx          <= next_arm_tx;
            arm_mf          <= next_arm_mf;
        end
    end

    // ****************************************************************
    // transfer sequencer and clock divider
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state    <= SPIBD_IDLE;
            edge_cnt <= 5'h00;
            div_cnt  <= 11'h000;
            sck_gen  <= 1'b0;
            sck_prev <= 1'b0;
            ss_prev  <= 1'b1;
        end
        else
        begin
            state    <= next_state;
            sck_prev <= sck_s;
            ss_prev  <= ss_s;
            if (load)
            begin
                edge_cnt <= 5'h00;
                div_cnt  <= 11'h000;
                sck_gen  <= cpol;
            end
            else
            begin
                if (sck_edge)
                    edge_cnt <= edge_cnt + 5'h01;
                div_cnt <= tick ? 11'h000 : div_cnt + 11'h001;
                if (m_edge)
                    sck_gen <= !sck_gen;
            end
        end
    end

    // ****************************************************************
    // bus answer, pins and interrupts
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            sck_out         <= 1'b0;
            sck_oe          <= 1'b0;
            mosi_out        <= 1'b0;
            mosi_oe         <= 1'b0;
            miso_out        <= 1'b0;
            miso_oe         <= 1'b0;
            ss_n_out        <= 1'b1;
            ss_n_oe         <= 1'b0;
            tx_irq          <= 1'b0;
            rx_fault_irq    <= 1'b0;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata    <= {24'h00_0000, rd_byte};
            sck_out  <= master ? sck_gen : cpol;
            sck_oe   <= en && master && !mf_set;              // [R22]
            mosi_out <= out_bit;
            mosi_oe  <= en && master && !mf_set;              // [R22]
            miso_out <= out_bit;
            miso_oe  <= en && !master && !ss_s;
            ss_n_out <= (state == SPIBD_IDLE);
            ss_n_oe  <= en && master && fault_detect_enable && select_output_enable;
            tx_irq   <= tx_empty_flag && control_reg_one[`SPIBD_C1_TXIE]; // [R06]
            rx_fault_irq <= (rx_full_flag || mode_fault_flag) &&
                            control_reg_one[`SPIBD_C1_RXIE];  // [R23]
        end
    end

endmodule

`default_nettype wire

// ==== test/spibd_assertions.sv ====
// port assertions for the spi data/status block
`timescale 1ns/1ps
`default_nettype none
module spibd_chk
#(
    parameter int ADDR_W = 5
)
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              sck_out,
    input wire logic              sck_oe,
    input wire logic              mosi_oe,
    input wire logic              miso_oe,
    input wire logic              ss_n_out,
    input wire logic              ss_n_oe,
    input wire logic              tx_irq,
    input wire logic              rx_fault_irq
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reset_idle_a:
        assert property ($rose(rst_n) |-> avs_waitrequest && ss_n_out
            && !sck_oe && !tx_irq && !rx_fault_irq)
        else $error("outputs not idle after reset");
    bus_answer_a:
        assert property ((avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    ack_once_a:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    upper_zero_a:
        assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    status_gaps_a:
        assert property (!avs_waitrequest && $past(avs_read)
            && $past(avs_address) == 5'h0C
            |-> avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)
        else $error("unused status bits not zero");
    frame_select_a:
        assert property (ss_n_oe && $changed(sck_out) |-> !ss_n_out)
        else $error("clock moved with select high");
    drivers_pair_a:
        assert property (mosi_oe == sck_oe)
        else $error("clock and data drivers differ");
    one_driver_a:
        assert property (!(miso_oe && mosi_oe))
        else $error("master and slave drivers both on");
endmodule
`default_nettype wire

// ==== test/spibd_remote.sv ====
// remote spi slave, clock phase one, msb first
`timescale 1ns/1ps
`default_nettype none
module spibd_remote
(
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output var  logic       miso,
    output var  logic [7:0] got,
    output var  int         fr
);
    // ****
    // shifter
    // ****
    logic [7:0] sh;
    int         n;
    initial
    begin
        miso = 1'b1;
        got = 8'h00;
        sh = 8'h00;
        fr = 0;
        n = 0;
    end
    always @(negedge ss_n) n = 0;
    always @(posedge sck)
        if (!ss_n)
        begin
            if (n % 8 == 0)
                sh = reply + fr[7:0];
            miso = sh[7];
            sh = sh << 1;
        end
    always @(negedge sck)
        if (!ss_n)
        begin
            got = {got[6:0], mosi};
            n++;
            if (n % 8 == 0)
                fr++;
        end
    always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

// ==== test/spibd_top_tb.sv ====
// self-checking bench for the spi data/status block
`timescale 1ns/1ps
`default_nettype none
module spibd_top_tb;
    // ****
    // signals and instances
    // ****
    logic        mclk, rst_n, avs_read, avs_write, tb_ss, rem_miso;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        avs_waitrequest, sck_out, sck_oe, mosi_out, mosi_oe;
    logic        miso_out, miso_oe, ss_n_out, ss_n_oe, tx_irq, rx_fault_irq;
    logic        tb_sck, tb_mosi;
    logic [7:0]  q, got, sq;
    int          err_total, n_compared, fr;
    wire logic   sck_pin = sck_oe ? sck_out : tb_sck;
    wire logic   mosi_pin = mosi_oe ? mosi_out : tb_mosi;
    wire logic   miso_pin = miso_oe ? miso_out : rem_miso;
    wire logic   ss_pin = ss_n_oe ? ss_n_out : tb_ss;
    spibd_top uut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .sck_in(sck_pin), .sck_out, .sck_oe,
        .mosi_in(mosi_pin), .mosi_out, .mosi_oe, .miso_in(miso_pin),
        .miso_out, .miso_oe, .ss_n_in(ss_pin), .ss_n_out, .ss_n_oe,
        .tx_irq, .rx_fault_irq);
    spibd_remote u_rem (.sck(sck_pin), .ss_n(ss_pin), .mosi(mosi_pin),
        .reply(8'hC3), .miso(rem_miso), .got, .fr);
    // ****
    // tasks
    // ****
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        int i;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (avs_waitrequest !== 1'b0 && i < 40);
        if (i >= 40)
        begin
            err_total++;
            stop_test();
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic poll(input int b);
        int i;
        q = 8'h00;
        for (i = 0; i < 200 && q[b] !== 1'b1; i++)
            acc(1'b0, 5'h0C, 8'h00);
        chk({7'h0, q[b]}, 8'h01);
    endtask
    task automatic wait_fr(input int n);
        int i;
        for (i = 0; i < 3000 && fr != n; i++)
            @(posedge mclk);
        chk(fr[7:0], n[7:0]);
    endtask
    // ****
    // sequence
    // ****
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        tb_ss = 1'b1;
        tb_sck = 1'b0;
        tb_mosi = 1'b1;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(5'h10, 8'h00);
        rd(5'h14, 8'h00);
        acc(1'b1, 5'h04, 8'h10);
        acc(1'b1, 5'h08, 8'h30);
        acc(1'b1, 5'h00, 8'hF6);
        acc(1'b1, 5'h10, 8'h11);
        repeat (100) @(posedge mclk);
        chk(fr[7:0], 8'h00);
        rd(5'h0C, 8'h20);
        chk({7'h0, tx_irq}, 8'h01);
        chk({7'h0, rx_fault_irq}, 8'h00);
        acc(1'b1, 5'h0C, 8'hFF);
        rd(5'h0C, 8'h20);
        acc(1'b1, 5'h10, 8'hA5);
        repeat (2) @(posedge mclk);
        rd(5'h0C, 8'h20);
        acc(1'b1, 5'h10, 8'h3C);
        rd(5'h0C, 8'h00);
        chk({7'h0, tx_irq}, 8'h00);
        poll(7);
        rd(5'h0C, 8'hA0);
        chk({7'h0, rx_fault_irq}, 8'h01);
        wait_fr(2);
        chk(got, 8'h3C);
        rd(5'h0C, 8'hA0);
        rd(5'h10, 8'hC3);
        rd(5'h0C, 8'h20);
        repeat (100) @(posedge mclk);
        chk(fr[7:0], 8'h02);
        acc(1'b1, 5'h00, 8'hF7);
        rd(5'h0C, 8'h20);
        acc(1'b1, 5'h10, 8'h01);
        wait_fr(3);
        chk(got, 8'h80);
        poll(7);
        rd(5'h10, 8'hA3);
        acc(1'b1, 5'h00, 8'hF4);
        tb_ss <= 1'b0;
        poll(4);
        chk({6'h0, sck_oe, mosi_oe}, 8'h00);
        chk({7'h0, rx_fault_irq}, 8'h01);
        tb_ss <= 1'b1;
        rd(5'h0C, 8'h30);
        acc(1'b1, 5'h00, 8'hF4);
        rd(5'h0C, 8'h20);
        acc(1'b1, 5'h00, 8'hE4);
        rd(5'h0C, 8'h20);
        acc(1'b1, 5'h10, 8'h5A);
        sq = 8'h96;
        tb_ss <= 1'b0;
        repeat (8) @(posedge mclk);
        repeat (8)
        begin
            tb_mosi <= sq[7];
            tb_sck <= 1'b1;
            repeat (4) @(posedge mclk);
            tb_sck <= 1'b0;
            repeat (4) @(posedge mclk);
            sq = {sq[6:0], miso_pin};
        end
        chk(sq, 8'h5A);
        tb_ss <= 1'b1;
        rd(5'h0C, 8'hA0);
        rd(5'h10, 8'h96);
        stop_test();
    end
endmodule
bind spibd_top spibd_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .sck_out, .sck_oe, .mosi_oe, .miso_oe, .ss_n_out, .ss_n_oe, .tx_irq,
    .rx_fault_irq);
`default_nettype wire
